/* File: design/bsg_pkg.sv */
// Package for the boot select and bus grant block: constants and carrier types
package bsg_pkg;

  // ------------------------------------------------------------------
  // Boot mode pin patterns {C,B,A}
  // ------------------------------------------------------------------
  localparam logic [2:0] BSG_MODE_DMA_FULL  = 3'h0;
  localparam logic [2:0] BSG_MODE_NO_BOOT   = 3'h2;
  localparam logic [2:0] BSG_MODE_DMA_SLAVE = 3'h4;
  localparam logic [2:0] BSG_MODE_HOST      = 3'h5;

  // ------------------------------------------------------------------
  // Byte DMA reset defaults and field widths
  // ------------------------------------------------------------------
  localparam int          BSG_ADDR_W        = 14;
  localparam int          BSG_PAGE_W        = 8;
  localparam int          BSG_COUNT_W       = 14;
  localparam logic [1:0]  BSG_FMT_PM24      = 2'h0;
  localparam logic [13:0] BSG_BOOT_WORDS    = 14'h0020;
  localparam logic [1:0]  BSG_BYTES_PM24    = 2'h3;
  localparam logic [13:0] BSG_ADDR_RST      = 14'h0000;
  localparam logic [7:0]  BSG_PAGE_RST      = 8'h00;
  localparam logic        BSG_DIR_RST       = 1'b0;

  // ------------------------------------------------------------------
  // Carrier types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    BSG_BOOT_NONE = 2'b00,
    BSG_BOOT_DMA  = 2'b01,
    BSG_BOOT_HOST = 2'b10
  } bsg_boot_t;

  // Byte DMA setup written by software
  typedef struct packed {
    logic                   transfer_dir;
    logic [BSG_PAGE_W-1:0]  byte_page;
    logic [BSG_ADDR_W-1:0]  internal_start_addr;
    logic [BSG_ADDR_W-1:0]  external_start_addr;
    logic [1:0]             transfer_format;
    logic [BSG_COUNT_W-1:0] word_count;
    logic                   context_reset_hold;
  } bsg_dma_cfg_t;

  // Core access request toward the external bus
  typedef struct packed {
    logic ext_access;   // An external access is in progress this cycle
    logic ext_needed;   // Next instruction needs the external bus
    logic second_pend;  // Second access of the same instruction pending
  } bsg_core_req_t;

endpackage : bsg_pkg

/* File: design/bsg_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module bsg_sync
  import bsg_pkg::*;
#(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic i_clock,
  input  wire logic i_sys_rst,
  input  wire logic i_async,
  output logic      o_level
);

  logic meta_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;
  logic agree;

  // ------------------------------------------------------------------
  // Chain; first stage read only by the second
  // ------------------------------------------------------------------
  assign agree = (s2_q == s3_q);

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      meta_q <= RESET_VAL;
      s2_q   <= RESET_VAL;
      s3_q   <= RESET_VAL;
      lvl_q  <= RESET_VAL;
    end else begin
      meta_q <= i_async;
      s2_q   <= meta_q;
      s3_q   <= s2_q;
      if (agree) begin
        lvl_q <= s3_q;
      end
    end
  end

  assign o_level = lvl_q;

endmodule // bsg_sync

`default_nettype wire

/* File: design/bsg_boot_grant.sv */
// Boot mode selection, byte DMA boot loader and bus request/grant arbiter
`timescale 1ns/1ps
`default_nettype none

module bsg_boot_grant
  import bsg_pkg::*;
#(
  parameter int COUNT_W = BSG_COUNT_W
) (
  input  wire logic                  i_clock,
  input  wire logic                  i_sys_rst,
  input  wire logic [2:0]            i_boot_mode,
  input  wire logic                  i_bus_request_n,
  input  wire logic                  i_run_on_grant,
  input  wire bsg_core_req_t         i_core_req,
  input  wire logic                  i_cfg_write,
  input  wire bsg_dma_cfg_t          i_cfg,
  input  wire logic                  i_byte_valid,
  input  wire logic [7:0]            i_byte_data,
  input  wire logic                  i_host_pm0_write,
  output logic                       o_bus_grant_n,
  output logic                       o_grant_hold_n,
  output logic                       o_pins_oe_n,
  output logic                       o_exec_halt,
  output logic                       o_exec_from_zero,
  output logic                       o_ext_boot_space,
  output logic                       o_slave_port,
  output logic                       o_byte_read,
  output logic                       o_low_addr_bit,
  output logic [BSG_ADDR_W-1:0]      o_ext_addr,
  output logic [BSG_PAGE_W-1:0]      o_page,
  output logic                       o_word_valid,
  output logic [23:0]                o_word_data,
  output logic [BSG_ADDR_W-1:0]      o_word_addr,
  output logic                       o_dma_done_irq,
  output bsg_boot_t                  o_boot_sel,
  output logic [COUNT_W-1:0]         o_word_count
);

  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    BSG_BUS_OWN   = 2'b00,
    BSG_BUS_WAIT  = 2'b01,
    BSG_BUS_GRANT = 2'b10
  } bsg_bus_t;

  bsg_bus_t               bus_q, bus_d;
  logic                   req_lvl_n;
  logic                   in_rst_q;
  bsg_boot_t              boot_q;
  logic                   slave_q;
  bsg_dma_cfg_t           cfg_q;
  logic                   active_q;
  logic [1:0]             byte_idx_q;
  logic [23:0]            shift_q;
  logic                   halt_boot_q;
  logic                   zero_q;
  logic                   word_v_q;
  logic                   irq_q;
  logic                   grant_n_q;
  logic                   hold_n_q;
  logic                   oe_n_q;
  logic                   halt_q;
  logic                   rd_q;
  logic [BSG_ADDR_W-1:0]  word_addr_q;
  logic [23:0]            word_data_q;
  logic                   ext_space_q;

  wire bsg_boot_t mode_dec;
  wire logic      mode_slave;
  wire logic [2:0] mode_lvl;
  wire logic      req_on;
  wire logic      byte_take;
  wire logic      word_end;
  wire logic      grant_ok;
  wire logic      boot_dma;
  wire logic      sw_start;
  wire logic [BSG_ADDR_W+BSG_PAGE_W-1:0] ext_lin;
  wire logic [BSG_ADDR_W+BSG_PAGE_W-1:0] ext_next;

  // ------------------------------------------------------------------
  // Request synchroniser; pin is outside the clock domain
  // ------------------------------------------------------------------
  bsg_sync #(.RESET_VAL(1'b1)) u_req_sync (
    .i_clock   (i_clock),
    .i_sys_rst (1'b0),               // Keeps sampling during reset
    .i_async   (i_bus_request_n),
    .o_level   (req_lvl_n)
  );

  // Boot straps are pins as well; same filter, also never reset
  generate
    for (genvar b = 0; b < 3; b++) begin : g_mode_sync
      bsg_sync #(.RESET_VAL(1'b0)) u_mode_sync (
        .i_clock   (i_clock),
        .i_sys_rst (1'b0),             // Tracks straps while reset is held
        .i_async   (i_boot_mode[b]),
        .o_level   (mode_lvl[b])
      );
    end
  endgenerate

  // ------------------------------------------------------------------
  // Boot pattern decoding
  // ------------------------------------------------------------------
  // Unlisted strap patterns fall back to no boot, so a bad strap still
  // leaves the core running from external memory instead of stuck
  assign mode_dec   = (mode_lvl == BSG_MODE_DMA_FULL)  ? BSG_BOOT_DMA  :
                      (mode_lvl == BSG_MODE_DMA_SLAVE) ? BSG_BOOT_DMA  :
                      (mode_lvl == BSG_MODE_HOST)      ? BSG_BOOT_HOST :
                                                         BSG_BOOT_NONE;
  assign mode_slave = mode_lvl[2];
  assign boot_dma   = (mode_dec == BSG_BOOT_DMA);

  // Capture at the first clock after reset release, then frozen
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      in_rst_q    <= 1'b1;
      boot_q      <= BSG_BOOT_NONE;
      slave_q     <= 1'b0;
      ext_space_q <= 1'b0;
    end else begin
      in_rst_q <= 1'b0;
      if (in_rst_q) begin
        boot_q      <= mode_dec;
        slave_q     <= mode_slave;
        ext_space_q <= (mode_dec == BSG_BOOT_NONE);
      end
    end
  end

  // ------------------------------------------------------------------
  // Byte DMA datapath; boot uses the 24-bit program format only
  // ------------------------------------------------------------------
  // Core accesses win: a byte fetch only goes out while the core leaves
  // the external bus idle and no grant is about to take it
  assign byte_take = active_q && i_byte_valid && rd_q;
  assign word_end  = byte_take && (byte_idx_q == BSG_BYTES_PM24 - 2'h1);
  assign sw_start  = i_cfg_write && (i_cfg.word_count != '0);
  assign ext_lin   = {cfg_q.byte_page, cfg_q.external_start_addr};
  assign ext_next  = ext_lin + {{(BSG_ADDR_W+BSG_PAGE_W-1){1'b0}}, 1'b1};   // Pages cross

  // Configuration, counting and word assembly
  // One transfer at a time: a write while busy is dropped, not queued,
  // so software must wait for the interrupt before the next setup
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      cfg_q.transfer_dir        <= BSG_DIR_RST;
      cfg_q.byte_page           <= BSG_PAGE_RST;
      cfg_q.internal_start_addr <= BSG_ADDR_RST;
      cfg_q.external_start_addr <= BSG_ADDR_RST;
      cfg_q.transfer_format     <= BSG_FMT_PM24;
      cfg_q.word_count          <= boot_dma ? BSG_BOOT_WORDS : '0;
      cfg_q.context_reset_hold  <= boot_dma;
      active_q    <= 1'b0;
      byte_idx_q  <= 2'h0;
      shift_q     <= 24'h000000;
      word_v_q    <= 1'b0;
      irq_q       <= 1'b0;
      word_addr_q <= BSG_ADDR_RST;
      word_data_q <= 24'h000000;
    end else begin
      word_v_q <= 1'b0;
      irq_q    <= 1'b0;
      if (in_rst_q && boot_q == BSG_BOOT_NONE && boot_dma) begin
        active_q <= 1'b1;
      end else if (sw_start && !active_q) begin
        cfg_q    <= i_cfg;
        active_q <= 1'b1;
      end
      if (byte_take) begin
        shift_q                   <= {shift_q[15:0], i_byte_data};
        {cfg_q.byte_page, cfg_q.external_start_addr} <= ext_next;
        byte_idx_q                <= word_end ? 2'h0 : byte_idx_q + 2'h1;
      end
      if (word_end) begin
        word_v_q    <= 1'b1;
        word_data_q <= {shift_q[15:0], i_byte_data};
        word_addr_q <= cfg_q.internal_start_addr;
        cfg_q.internal_start_addr <= cfg_q.internal_start_addr + 14'h0001;
        cfg_q.word_count <= cfg_q.word_count - 14'h0001;
        if (cfg_q.word_count == 14'h0001) begin
          active_q <= 1'b0;
          irq_q    <= 1'b1;
        end
      end
    end
  end

  // Execution hold for boot modes; released at completion or host write
  // Only the boot transfer's own completion or the host write frees the core; a software
  // transfer with the hold bit clear never touches execution
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      halt_boot_q <= 1'b1;
      zero_q      <= 1'b0;
    end else if (in_rst_q) begin
      halt_boot_q <= (mode_dec != BSG_BOOT_NONE);
      zero_q      <= 1'b0;
    end else begin
      zero_q <= 1'b0;
      if (halt_boot_q && boot_q == BSG_BOOT_DMA && irq_q && cfg_q.context_reset_hold) begin
        halt_boot_q <= 1'b0;
        zero_q      <= 1'b1;
      end else if (halt_boot_q && boot_q == BSG_BOOT_HOST && i_host_pm0_write) begin
        halt_boot_q <= 1'b0;
        zero_q      <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Bus arbiter; never reset-gated so it works in reset
  // ------------------------------------------------------------------
  assign req_on   = !req_lvl_n;
  assign grant_ok = !i_core_req.ext_access;

  // A request that meets a running access parks in WAIT; the idle gap
  // between two accesses of one instruction is enough to grant, so the
  // pending-second-access hint is not needed to find it
  always_comb begin
    bus_d = bus_q;
    case (bus_q)
      BSG_BUS_OWN: begin
        if (req_on) begin
          bus_d = grant_ok ? BSG_BUS_GRANT : BSG_BUS_WAIT;
        end
      end
      BSG_BUS_WAIT: begin
        if (!req_on) begin
          bus_d = BSG_BUS_OWN;
        end else if (grant_ok) begin
          bus_d = BSG_BUS_GRANT;
        end
      end
      BSG_BUS_GRANT: begin
        if (!req_on) begin
          bus_d = BSG_BUS_OWN;
        end
      end
      default: bus_d = BSG_BUS_OWN;
    endcase
  end

  // Grant state and registered pin controls
  // Driven from the next state so grant, float and (with i_run_on_grant low) halt move on one edge
  // and the pins never see a cycle with both sides driving
  always_ff @(posedge i_clock) begin
    bus_q     <= bus_d;
    grant_n_q <= (bus_d != BSG_BUS_GRANT);
    oe_n_q    <= (bus_d == BSG_BUS_GRANT);
    hold_n_q  <= !((bus_d == BSG_BUS_GRANT) &&
                   (!i_run_on_grant || i_core_req.ext_needed));
    halt_q    <= halt_boot_q ||
                 ((bus_d == BSG_BUS_GRANT) &&
                  (!i_run_on_grant || i_core_req.ext_needed));
    rd_q      <= active_q && (bus_d != BSG_BUS_GRANT) && !i_core_req.ext_access;
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign o_bus_grant_n    = grant_n_q;
  assign o_grant_hold_n   = hold_n_q;
  assign o_pins_oe_n      = oe_n_q;
  assign o_exec_halt      = halt_q;
  assign o_exec_from_zero = zero_q;
  assign o_ext_boot_space = ext_space_q;
  assign o_slave_port     = slave_q;
  assign o_byte_read      = rd_q;
  assign o_low_addr_bit   = cfg_q.external_start_addr[0];
  assign o_ext_addr       = cfg_q.external_start_addr;
  assign o_page           = cfg_q.byte_page;
  assign o_word_valid     = word_v_q;
  assign o_word_data      = word_data_q;
  assign o_word_addr      = word_addr_q;
  assign o_dma_done_irq   = irq_q;
  assign o_boot_sel       = boot_q;
  assign o_word_count     = cfg_q.word_count;

endmodule // bsg_boot_grant

`default_nettype wire

/* File: verif/bsg_boot_grant_properties.sv */
// Checker for the bus grant handshake and boot selection
`timescale 1ns/1ps
`default_nettype none

module bsg_boot_grant_properties
  import bsg_pkg::*;
(
  input wire logic          i_clock,
  input wire logic          i_sys_rst,
  input wire logic          i_bus_request_n,
  input wire logic          i_run_on_grant,
  input wire bsg_core_req_t i_core_req,
  input wire logic          o_bus_grant_n,
  input wire logic          o_grant_hold_n,
  input wire logic          o_pins_oe_n,
  input wire logic          o_exec_halt,
  input wire bsg_boot_t     o_boot_sel
);
  // ----------------------------------------------------------------
  // Grant handshake
  // ----------------------------------------------------------------
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  // Request path is synchronised, so eight cycles leave margin
  property p_take; (!i_bus_request_n && !i_core_req.ext_access) [*8] |-> !o_bus_grant_n; endproperty
  a_take: assert property (p_take) else $error("grant missing");
  property p_float; !o_bus_grant_n |-> o_pins_oe_n; endproperty
  a_float: assert property (p_float) else $error("pins driven while granted");
  property p_halt; !o_bus_grant_n && !i_run_on_grant |-> o_exec_halt; endproperty
  a_halt: assert property (p_halt) else $error("running while granted");
  property p_wait_acc; $fell(o_bus_grant_n) |-> !$past(i_core_req.ext_access); endproperty
  a_wait_acc: assert property (p_wait_acc) else $error("grant inside access");
  property p_give_back; i_bus_request_n [*8] |-> o_bus_grant_n; endproperty
  a_give_back: assert property (p_give_back) else $error("grant kept");
  property p_release; $rose(o_bus_grant_n) |-> !o_pins_oe_n && o_grant_hold_n; endproperty
  a_release: assert property (p_release) else $error("partial release");
  property p_hold_need; (!o_bus_grant_n && i_core_req.ext_needed) [*3] |-> !o_grant_hold_n; endproperty
  a_hold_need: assert property (p_hold_need) else $error("hold missing");
  property p_rog_stop;
    (!o_bus_grant_n && i_run_on_grant && i_core_req.ext_needed) [*3] |-> o_exec_halt;
  endproperty
  a_rog_stop: assert property (p_rog_stop) else $error("no stop on access");
  property p_sel_hold; !$past(i_sys_rst) && !$past(i_sys_rst, 2) |-> $stable(o_boot_sel); endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("boot selection moved");
endmodule // bsg_boot_grant_properties

bind bsg_boot_grant bsg_boot_grant_properties u_bsg_boot_grant_properties (
  .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_bus_request_n(i_bus_request_n),
  .i_run_on_grant(i_run_on_grant), .i_core_req(i_core_req), .o_bus_grant_n(o_bus_grant_n),
  .o_grant_hold_n(o_grant_hold_n), .o_pins_oe_n(o_pins_oe_n), .o_exec_halt(o_exec_halt),
  .o_boot_sel(o_boot_sel));

`default_nettype wire

/* File: verif/bsg_byte_mem_model.sv */
// Byte memory model with a programmable number of wait cycles
`timescale 1ns/1ps
`default_nettype none

module bsg_byte_mem_model (
  input  wire logic        i_clock,
  input  wire logic        i_sys_rst,
  input  wire logic        i_byte_read,
  input  wire logic        i_slave_port,
  input  wire logic        i_low_addr_bit,
  input  wire logic [13:0] i_ext_addr,
  input  wire logic [7:0]  i_page,
  input  wire logic [1:0]  i_wait,
  output logic             o_byte_valid = 1'b0,
  output logic [7:0]       o_byte_data = 8'hC3
);
  logic [1:0]  cnt_q;
  logic [13:0] seq_q;
  logic [13:0] addr;
  logic [7:0]  pg;
  // Slave port: upper bits come from our own counter
  assign addr = i_slave_port ? {seq_q[13:1], i_low_addr_bit} : i_ext_addr;
  assign pg = i_slave_port ? 8'h00 : i_page;
  // One byte per fetch; data toggles when not valid so stale bytes never match
  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      cnt_q <= 2'h0;
      seq_q <= 14'h0000;
      o_byte_valid <= 1'b0;
    end else if (i_byte_read && !o_byte_valid && cnt_q >= i_wait) begin
      o_byte_valid <= 1'b1;
      o_byte_data <= addr[7:0] ^ pg ^ 8'h5A;
      seq_q <= seq_q + 14'h0001;
      cnt_q <= 2'h0;
    end else begin
      o_byte_valid <= 1'b0;
      o_byte_data <= ~o_byte_data;
      cnt_q <= i_byte_read ? cnt_q + 2'h1 : 2'h0;
    end
  end
endmodule // bsg_byte_mem_model

`default_nettype wire

/* File: verif/bsg_boot_grant_tb.sv */
// Self-checking testbench for the boot select and bus grant block
`timescale 1ns/1ps
`default_nettype none

module bsg_boot_grant_tb;
  import bsg_pkg::*;
  localparam logic [2:0] MODES [4] = '{BSG_MODE_DMA_FULL, BSG_MODE_DMA_SLAVE,
                                       BSG_MODE_HOST, BSG_MODE_NO_BOOT};
  localparam bsg_boot_t SELS [4] = '{BSG_BOOT_DMA, BSG_BOOT_DMA, BSG_BOOT_HOST, BSG_BOOT_NONE};
  logic i_clock = 1'b0, i_sys_rst = 1'b1, i_bus_request_n = 1'b1, i_run_on_grant = 1'b0;
  logic i_cfg_write = 1'b0, i_host_pm0_write = 1'b0, byte_valid;
  logic [2:0] i_boot_mode = 3'h0;
  logic [1:0] wait_sel = 2'h0;
  bsg_core_req_t i_core_req = '0;
  bsg_dma_cfg_t i_cfg = '0;
  logic o_bus_grant_n, o_grant_hold_n, o_pins_oe_n, o_exec_halt, o_exec_from_zero;
  logic o_slave_port, o_byte_read, o_low_addr_bit, o_word_valid, o_dma_done_irq;
  logic [13:0] o_ext_addr, o_word_addr, o_word_count;
  logic [7:0] o_page, byte_data;
  logic [23:0] o_word_data;
  logic o_ext_boot_space;
  bsg_boot_t o_boot_sel;
  logic [37:0] exp_q [$];
  int errors = 0, check_count = 0, cycles = 0, irq_seen = 0, n;

  bsg_boot_grant u_bsg_boot_grant (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_boot_mode(i_boot_mode), .i_bus_request_n(i_bus_request_n),
    .i_run_on_grant(i_run_on_grant), .i_core_req(i_core_req), .i_cfg_write(i_cfg_write),
    .i_cfg(i_cfg), .i_byte_valid(byte_valid), .i_byte_data(byte_data),
    .i_host_pm0_write(i_host_pm0_write), .o_bus_grant_n(o_bus_grant_n),
    .o_grant_hold_n(o_grant_hold_n), .o_pins_oe_n(o_pins_oe_n), .o_exec_halt(o_exec_halt),
    .o_exec_from_zero(o_exec_from_zero), .o_ext_boot_space(o_ext_boot_space),
    .o_slave_port(o_slave_port),
    .o_byte_read(o_byte_read), .o_low_addr_bit(o_low_addr_bit), .o_ext_addr(o_ext_addr),
    .o_page(o_page), .o_word_valid(o_word_valid), .o_word_data(o_word_data),
    .o_word_addr(o_word_addr), .o_dma_done_irq(o_dma_done_irq), .o_boot_sel(o_boot_sel),
    .o_word_count(o_word_count));
  bsg_byte_mem_model u_bsg_byte_mem_model (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_byte_read(o_byte_read), .i_slave_port(o_slave_port), .i_low_addr_bit(o_low_addr_bit),
    .i_ext_addr(o_ext_addr), .i_page(o_page), .i_wait(wait_sel), .o_byte_valid(byte_valid),
    .o_byte_data(byte_data));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  always #20 i_clock = ~i_clock;
  task automatic step;
    @(posedge i_clock);
    #2;
  endtask
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Three bytes per word, first byte is the top one
  task automatic expect_words(input logic [7:0] pg, input logic [13:0] ia, input logic [13:0] ea,
                              input int cnt);
    logic [13:0] e;
    for (int k = 0; k < cnt; k++) begin
      e = 14'(ea + 3 * k);
      exp_q.push_back({14'(ia + k), e[7:0] ^ pg ^ 8'h5A, 8'(e + 1) ^ pg ^ 8'h5A,
                       8'(e + 2) ^ pg ^ 8'h5A});
    end
  endtask
  // Reset with a bus request inside it; grant must still work
  task automatic do_reset(input logic [2:0] mode);
    i_sys_rst = 1'b1;
    i_boot_mode = mode;
    i_bus_request_n = 1'b0;
    repeat (12) step;
    check(o_bus_grant_n, 1'b0);
    i_bus_request_n = 1'b1;
    repeat (8) step;
    check(o_bus_grant_n, 1'b1);
    if (mode == BSG_MODE_DMA_FULL || mode == BSG_MODE_DMA_SLAVE)
      check({o_word_count, o_page, o_ext_addr}, {BSG_BOOT_WORDS, 22'h0});
    i_sys_rst = 1'b0;
  endtask
  // Request while an access runs, grant in the gap, then give back
  task automatic grant_test(input logic rog);
    i_run_on_grant = rog;
    i_core_req = 3'b101;
    i_bus_request_n = 1'b0;
    repeat (10) step;
    check(o_bus_grant_n, 1'b1);
    i_core_req.ext_access = 1'b0;
    for (n = 0; n < 4 && o_bus_grant_n !== 1'b0; n++) step;
    check({o_bus_grant_n, o_pins_oe_n, o_exec_halt}, {2'b01, !rog});
    i_core_req = 3'b010;
    // Long enough for the three-cycle hold and stop windows of the checker
    repeat (8) step;
    check({o_grant_hold_n, o_exec_halt}, 2'b01);
    i_bus_request_n = 1'b1;
    for (n = 0; n < 10 && o_bus_grant_n !== 1'b1; n++) step;
    check({o_bus_grant_n, o_pins_oe_n, o_grant_hold_n}, 3'b101);
    i_core_req = '0;
    repeat (3) step;
    check(o_exec_halt, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // Scoreboard and watchdog
  // ----------------------------------------------------------------
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      tally_and_finish;
    end
    if (o_dma_done_irq === 1'b1) irq_seen++;
    if (o_word_valid === 1'b1) begin
      if (exp_q.size() == 0) check(1'b1, 1'b0);
      else check({o_word_addr, o_word_data}, exp_q.pop_front());
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(44));
    for (int m = 0; m < 4; m++) begin
      wait_sel = 2'($urandom_range(0, 3));
      irq_seen = 0;
      if (SELS[m] == BSG_BOOT_DMA) expect_words(8'h00, 14'h0, 14'h0, 32);
      do_reset(MODES[m]);
      step;
      i_boot_mode = 3'($urandom);
      check({o_boot_sel, o_slave_port}, {SELS[m], MODES[m][2]});
      step;
      check(o_ext_boot_space, SELS[m] == BSG_BOOT_NONE);
      check(o_exec_halt, SELS[m] != BSG_BOOT_NONE);
      if (SELS[m] == BSG_BOOT_NONE) check(o_byte_read, 1'b0);
      else begin
        if (SELS[m] == BSG_BOOT_HOST) begin
          repeat (10) step;
          check(o_exec_halt, 1'b1);
          i_host_pm0_write = 1'b1;
          step;
          i_host_pm0_write = 1'b0;
        end
        for (n = 0; n < 4000 && o_exec_from_zero !== 1'b1; n++) step;
        check(o_exec_from_zero, 1'b1);
        step;
        check(o_exec_halt, 1'b0);
        if (SELS[m] == BSG_BOOT_DMA)
          check({o_word_count, exp_q.size() == 0, irq_seen != 0}, 16'h0003);
      end
    end
    // Software transfer; a second write while busy must be ignored
    i_cfg.byte_page = 8'($urandom);
    i_cfg.internal_start_addr = 14'($urandom);
    i_cfg.external_start_addr = 14'($urandom_range(0, 8000));
    i_cfg.word_count = 14'($urandom_range(1, 3));
    expect_words(i_cfg.byte_page, i_cfg.internal_start_addr, i_cfg.external_start_addr,
                 int'(i_cfg.word_count));
    irq_seen = 0;
    i_cfg_write = 1'b1;
    step;
    i_cfg_write = 1'b0;
    step;
    i_cfg.word_count = 14'h0005;
    i_cfg_write = 1'b1;
    step;
    i_cfg_write = 1'b0;
    for (n = 0; n < 500 && irq_seen == 0; n++) step;
    repeat (4) step;
    check({exp_q.size() == 0, o_word_count, o_exec_halt, irq_seen == 1},
          {1'b1, 14'h0000, 1'b0, 1'b1});
    grant_test(1'b0);
    grant_test(1'b1);
    tally_and_finish;
  end
endmodule // bsg_boot_grant_tb

`default_nettype wire
